/* File: cmec_regs.svh */
// register addresses, field positions and reset values of the core memory error counters
`ifndef CMEC_REGS_SVH
`define CMEC_REGS_SVH
`define CMEC_ADDR_ICACHE      12'h7F0
`define CMEC_ADDR_IMEM        12'h7F1
`define CMEC_CNT_MSB          26
`define CMEC_THR_LSB          27
`define CMEC_THR_MSB          31
`define CMEC_THR_MAX          5'h1A
`define CMEC_CNT_RST          27'h0000000
`define CMEC_THR_RST          5'h00
`define CMEC_CNT_ONE          27'h0000001
`define CMEC_DATA_W           32
`define CMEC_ECC_W            7
`endif

/* File: cmec_pkg.sv */
// types shared by the core memory error counter design
package cmec_pkg;
   typedef logic [26:0] cmec_count_type;
   typedef logic [4:0]  cmec_thresh_type;
   // outcome of one access check
   typedef enum logic [1:0] {
      CMEC_OK   = 2'b00,
      CMEC_SBE  = 2'b01,
      CMEC_DBE  = 2'b11
   } cmec_ecc_type;
endpackage

/* File: cmec_counter.sv */
// one error counter/threshold register with its interrupt condition
`timescale 1ns/10ps
`include "cmec_regs.svh"
module cmec_counter
   import cmec_pkg::*;
(
   // clock and reset
   input  wire logic            clk,
   input  wire logic            rst,
   // register access
   input  wire logic            wr_en,
   input  wire logic [31:0]     wr_data,
   // hardware event
   input  wire logic            inc,
   // state
   output logic [31:0]          rd_data,
   output logic                 irq
);
   cmec_count_type  count_q;
   cmec_thresh_type thresh_q;
   cmec_thresh_type thr_wr;

   // out-of-range thresholds are folded to the top count bit
   assign thr_wr = (wr_data[`CMEC_THR_MSB:`CMEC_THR_LSB] > `CMEC_THR_MAX) ?
                   `CMEC_THR_MAX : wr_data[`CMEC_THR_MSB:`CMEC_THR_LSB];

   // threshold, read/write only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         thresh_q <= `CMEC_THR_RST;
      end else if (wr_en) begin
         thresh_q <= thr_wr;
      end
   end

   // count: software write takes the cycle, otherwise wrap-around increment
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_q <= `CMEC_CNT_RST;
      end else if (wr_en) begin
         count_q <= wr_data[`CMEC_CNT_MSB:0];
      end else if (inc) begin
         count_q <= count_q + `CMEC_CNT_ONE;
      end
   end

   // reads have no side effect
   assign rd_data = {thresh_q, count_q};
   // level, not sticky; clearing the count drops it
   assign irq     = count_q[thresh_q];
endmodule // cmec_counter

/* File: cmec_core_mem_errors.sv */
// error handling and counting for the core's local memories
// What this block does
// - data memory keeps seven check bits per word
// - data single-bit: correct, write back on retire
// - data uncorrectable: access fault or DMA error
// - flagged system data discarded, fault or NMI
// - every fetch single-bit error fixed; counted unless a 0x7F1 write takes the same cycle
// - fetch single-bit: flush and refetch, no inline fix
// - fetch fatal fault only when oldest instruction
// - no address logged, only counts
// - cache counter counts tag or data errors
// - instruction memory counter: fetch or DMA read
// - count bits 26:0, threshold 31:27, reset zero
// - threshold 27 to 31 stored as 26
// - interrupt while selected count bit is one
// - reads harmless, writes set both fields
// - count wraps, no saturation
// - instruction memory DMA single-bit errors counted in any power state
// - illegal writes converted to legal values
// - registers at 0x7F0 and 0x7F1
// - several cache errors in a cycle count once
`timescale 1ns/10ps
`include "cmec_regs.svh"
module cmec_core_mem_errors
   import cmec_pkg::*;
(
   // clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst,
   // control/status register port
   input  wire logic                        csr_wr_en,
   input  wire logic [11:0]                 csr_addr,
   input  wire logic [31:0]                 csr_wr_data,
   output logic [31:0]                      csr_rd_data,
   output logic                             csr_hit,
   // instruction cache checks, one bit per tag way and per data chunk
   input  wire logic [3:0]                  ic_tag_err,
   input  wire logic [3:0]                  ic_data_err,
   // instruction memory fetch check
   input  wire logic                        ifetch_valid,
   input  wire cmec_ecc_type                ifetch_ecc,
   input  wire logic                        ifetch_oldest,
   // instruction memory DMA read check
   input  wire logic                        imem_dma_valid,
   input  wire cmec_ecc_type                imem_dma_ecc,
   // data memory load/store check
   input  wire logic                        dmem_valid,
   input  wire logic                        dmem_is_store,
   input  wire logic                        dmem_nonspec,
   input  wire logic                        dmem_retire,
   input  wire logic [`CMEC_DATA_W-1:0]     dmem_raw_data,
   input  wire logic [`CMEC_ECC_W-1:0]      dmem_raw_ecc,
   input  wire cmec_ecc_type                dmem_ecc,
   input  wire logic [`CMEC_DATA_W-1:0]     dmem_fix_data,
   input  wire logic [`CMEC_ECC_W-1:0]      dmem_fix_ecc,
   // data memory DMA read check
   input  wire logic                        dmem_dma_valid,
   input  wire cmec_ecc_type                dmem_dma_ecc,
   // system memory responses
   input  wire logic                        sys_rsp_valid,
   input  wire logic                        sys_rsp_err,
   input  wire logic [1:0]                  sys_rsp_kind,
   // pipeline results
   output logic [`CMEC_DATA_W-1:0]          dmem_load_data,
   output logic                             dmem_wb_en,
   output logic [`CMEC_DATA_W-1:0]          dmem_wb_data,
   output logic [`CMEC_ECC_W-1:0]           dmem_wb_ecc,
   output logic                             imem_wb_en,
   output logic                             refetch_flush,
   output logic                             instr_access_fault,
   output logic                             load_access_fault,
   output logic                             store_access_fault,
   output logic                             store_bus_error_nmi,
   output logic                             sys_data_discard,
   output logic                             dma_err_rsp,
   // correctable error local interrupts
   output logic                             ic_err_irq,
   output logic                             imem_err_irq,
   output logic                             corr_err_irq
);
   // system response kinds
   localparam logic [1:0] KIND_FETCH = 2'b00;
   localparam logic [1:0] KIND_LOAD  = 2'b01;
   localparam logic [1:0] KIND_STORE = 2'b10;

   logic        ic_inc;
   logic        imem_inc;
   logic        wr_ic;
   logic        wr_im;
   logic [31:0] rd_ic;
   logic [31:0] rd_im;
   logic        dmem_sbe_ret;
   // decoded events; fetch_sbe, dmem_dbe_ns and sys_fatal each feed more than one result
   logic        fetch_sbe;
   logic        fetch_dbe_old;
   logic        imdma_sbe;
   logic        imdma_dbe;
   logic        dmdma_dbe;
   logic        dmem_dbe_ns;
   logic        sys_fatal;

   // timing of this block, as seen from the pipeline:
   //  - every check input is a single-cycle level, taken at the rising edge
   //  - every fault, flush and write-back strobe is registered, so it
   //    stands for exactly the cycle after its cause; the pipeline must
   //    act on it then, there is no second chance
   //  - the two counters answer reads combinationally in the same cycle
   //  - a register write and a hardware increment in one cycle: the write
   //    wins and the increment is lost; firmware clearing the count is the
   //    usual reason to write, so losing one event there is harmless
   //  - the interrupt levels follow the counters with no extra delay
   // limitation: no address or syndrome is kept for any error, so a
   // recurring fault can be seen by its rate only, not by its location
   // decode used for every checked access
   function automatic logic is_sbe(input cmec_ecc_type e);
      is_sbe = (e == CMEC_SBE);
   endfunction

   function automatic logic is_dbe(input cmec_ecc_type e);
      is_dbe = (e == CMEC_DBE);
   endfunction

   // any number of cache hits in one cycle gives a single increment
   assign ic_inc = (|ic_tag_err) | (|ic_data_err);

   // fetch errors count whether or not the instruction executes;
   // DMA path ignores power and halt state on purpose
   assign imem_inc = (ifetch_valid & is_sbe(ifetch_ecc)) |
                     (imem_dma_valid & is_sbe(imem_dma_ecc));

   // register select
   assign wr_ic   = csr_wr_en & (csr_addr == `CMEC_ADDR_ICACHE);
   assign wr_im   = csr_wr_en & (csr_addr == `CMEC_ADDR_IMEM);
   assign csr_hit = (csr_addr == `CMEC_ADDR_ICACHE) | (csr_addr == `CMEC_ADDR_IMEM);

   // only counts are kept, no address capture anywhere
   cmec_counter u_ic_cnt (
      .clk     (clk),
      .rst     (rst),
      .wr_en   (wr_ic),
      .wr_data (csr_wr_data),
      .inc     (ic_inc),
      .rd_data (rd_ic),
      .irq     (ic_err_irq)
   );

   cmec_counter u_im_cnt (
      .clk     (clk),
      .rst     (rst),
      .wr_en   (wr_im),
      .wr_data (csr_wr_data),
      .inc     (imem_inc),
      .rd_data (rd_im),
      .irq     (imem_err_irq)
   );

   // read mux, unmapped addresses read zero
   always_comb begin
      case (csr_addr)
         `CMEC_ADDR_ICACHE: csr_rd_data = rd_ic;
         `CMEC_ADDR_IMEM:   csr_rd_data = rd_im;
         default:           csr_rd_data = 32'h00000000;
      endcase
   end

   assign corr_err_irq = ic_err_irq | imem_err_irq;

   // data memory single-bit write back only for a retiring access
   assign dmem_sbe_ret = dmem_valid & is_sbe(dmem_ecc) & dmem_retire;

   // fetch and dma decodes; a younger fatal fetch is left to be refetched
   assign fetch_sbe     = ifetch_valid & is_sbe(ifetch_ecc);
   assign fetch_dbe_old = ifetch_valid & is_dbe(ifetch_ecc) & ifetch_oldest;
   assign imdma_sbe     = imem_dma_valid & is_sbe(imem_dma_ecc);
   assign imdma_dbe     = imem_dma_valid & is_dbe(imem_dma_ecc);
   assign dmdma_dbe     = dmem_dma_valid & is_dbe(dmem_dma_ecc);
   // speculative data accesses never fault, they may yet be squashed
   assign dmem_dbe_ns   = dmem_valid & is_dbe(dmem_ecc) & dmem_nonspec;
   // flagged system data is dropped whatever the access kind
   assign sys_fatal     = sys_rsp_valid & sys_rsp_err;

   // corrected load data goes out registered; the 7-bit code is checked upstream
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dmem_load_data <= '0;
      end else if (dmem_valid) begin
         dmem_load_data <= is_sbe(dmem_ecc) ? dmem_fix_data : dmem_raw_data;
      end
   end

   // data memory write back of the corrected word and check bits
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dmem_wb_en   <= 1'b0;
         dmem_wb_data <= '0;
         dmem_wb_ecc  <= '0;
      end else begin
         dmem_wb_en <= dmem_sbe_ret;
         if (dmem_sbe_ret) begin
            dmem_wb_data <= dmem_fix_data;
            dmem_wb_ecc  <= dmem_fix_ecc;
         end
      end
   end

   // fetch single-bit: no in-line fix because it would cost a cycle;
   // a stuck bit here can loop refetching forever
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         refetch_flush <= 1'b0;
      end else begin
         refetch_flush <= fetch_sbe;
      end
   end

   // instruction memory write back, for fetches and dma reads alike
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         imem_wb_en <= 1'b0;
      end else begin
         imem_wb_en <= fetch_sbe | imdma_sbe;
      end
   end

   // instruction access fault: oldest fatal fetch or flagged system fetch
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         instr_access_fault <= 1'b0;
      end else begin
         instr_access_fault <= fetch_dbe_old |
                               (sys_fatal & (sys_rsp_kind == KIND_FETCH));
      end
   end

   // load access fault: local uncorrectable load or flagged system load
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         load_access_fault <= 1'b0;
      end else begin
         load_access_fault <= (dmem_dbe_ns & ~dmem_is_store) |
                              (sys_fatal & (sys_rsp_kind == KIND_LOAD));
      end
   end

   // store/amo access fault: local memory only, system stores use the nmi
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         store_access_fault <= 1'b0;
      end else begin
         store_access_fault <= dmem_dbe_ns & dmem_is_store;
      end
   end

   // system stores are posted, so the error can only come back as an nmi
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         store_bus_error_nmi <= 1'b0;
      end else begin
         store_bus_error_nmi <= sys_fatal & (sys_rsp_kind == KIND_STORE);
      end
   end

   // tells the fetch and load paths to drop the flagged system word
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sys_data_discard <= 1'b0;
      end else begin
         sys_data_discard <= sys_fatal;
      end
   end

   // error response to the dma master for either local memory
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dma_err_rsp <= 1'b0;
      end else begin
         dma_err_rsp <= dmdma_dbe | imdma_dbe;
      end
   end
endmodule // cmec_core_mem_errors

/* File: cmec_core_mem_errors_asserts.sv */
// concurrent checks on the core memory error counter ports
`timescale 1ns/10ps
module cmec_core_mem_errors_asserts
   import cmec_pkg::*;
(
   // clock, reset and register port
   input wire logic         clk, rst, csr_hit,
   input wire logic [11:0]  csr_addr,
   input wire logic [31:0]  csr_rd_data,
   // events
   input wire logic         ifetch_valid, ifetch_oldest, dmem_valid, dmem_is_store, dmem_nonspec,
   input wire logic         dmem_retire, dmem_dma_valid, sys_rsp_valid, sys_rsp_err,
   input wire cmec_ecc_type ifetch_ecc, dmem_ecc, dmem_dma_ecc,
   input wire logic [1:0]   sys_rsp_kind,
   // results
   input wire logic         refetch_flush, imem_wb_en, instr_access_fault, load_access_fault,
   input wire logic         store_access_fault, dmem_wb_en, dma_err_rsp, store_bus_error_nmi,
   input wire logic         sys_data_discard, ic_err_irq, imem_err_irq, corr_err_irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // fetch single error: flagged fetch, then flush with write-back
   sequence s_fetch_sbe; ifetch_valid && ifetch_ecc == CMEC_SBE; endsequence
   sequence s_flush_wb; refetch_flush && imem_wb_en; endsequence
   a_fetch_sbe_flush: assert property (s_fetch_sbe |=> s_flush_wb)
      else $error("fetch single error gave no flush");
   a_fetch_fatal_old: assert property (ifetch_valid && ifetch_ecc == CMEC_DBE && ifetch_oldest
      |=> instr_access_fault) else $error("oldest fatal fetch not faulted");
   // write-back only for a retired single-bit access
   a_dmem_wb_retire: assert property (dmem_wb_en |->
      $past(dmem_valid && dmem_retire && dmem_ecc == CMEC_SBE)) else $error("bad write-back");
   a_load_fault: assert property (dmem_valid && dmem_ecc == CMEC_DBE && !dmem_is_store
      && dmem_nonspec |=> load_access_fault) else $error("load fault missing");
   a_store_fault_src: assert property (store_access_fault |->
      $past(dmem_valid && dmem_is_store && dmem_nonspec && dmem_ecc == CMEC_DBE))
      else $error("store fault without cause");
   a_dma_err_rsp: assert property (dmem_dma_valid && dmem_dma_ecc == CMEC_DBE |=> dma_err_rsp)
      else $error("dma error response missing");
   a_sys_store_nmi: assert property (sys_rsp_valid && sys_rsp_err && sys_rsp_kind == 2'b10
      |=> store_bus_error_nmi && sys_data_discard) else $error("store nmi missing");
   // interrupt follows the selected count bit, never latched
   a_irq_select: assert property (csr_addr == 12'h7F0 |->
      ic_err_irq == csr_rd_data[csr_rd_data[31:27]]) else $error("cache irq wrong");
   a_irq_or_both: assert property (corr_err_irq == (ic_err_irq || imem_err_irq))
      else $error("combined irq wrong");
   a_thr_legal: assert property (csr_hit |-> csr_rd_data[31:27] <= 5'h1A)
      else $error("illegal threshold read");
   a_unmapped_zero: assert property (!csr_hit |-> csr_rd_data == 32'h0)
      else $error("unmapped read not zero");
endmodule // cmec_core_mem_errors_asserts

/* File: cmec_pipe_model.sv */
// behavioural pipeline, memory and dma side that raises check events
`timescale 1ns/10ps
module cmec_pipe_model
   import cmec_pkg::*;
(
   // clock
   input wire logic clk,
   // events toward the counters
   output logic [3:0]   ic_tag_err, ic_data_err,
   output logic         ifetch_valid, ifetch_oldest, imem_dma_valid, dmem_valid, dmem_is_store,
   output logic         dmem_nonspec, dmem_retire, dmem_dma_valid, sys_rsp_valid, sys_rsp_err,
   output cmec_ecc_type ifetch_ecc, imem_dma_ecc, dmem_ecc, dmem_dma_ecc,
   output logic [1:0]   sys_rsp_kind,
   output logic [31:0]  dmem_raw_data, dmem_fix_data,
   output logic [6:0]   dmem_raw_ecc, dmem_fix_ecc
);
   // idle: strobes low, data lines toggle so a stale word never looks valid
   task automatic quiet();
      {ic_tag_err, ic_data_err, ifetch_valid, ifetch_oldest, imem_dma_valid, dmem_valid} = '0;
      {dmem_is_store, dmem_nonspec, dmem_retire, dmem_dma_valid, sys_rsp_valid} = '0;
      {sys_rsp_err, sys_rsp_kind} = '0;
      {ifetch_ecc, imem_dma_ecc, dmem_ecc, dmem_dma_ecc} = {4{CMEC_OK}};
      dmem_fix_data = ~dmem_fix_data;
      dmem_raw_data = ~dmem_fix_data;
      dmem_fix_ecc = ~dmem_fix_ecc; // check bits travel with each word
      dmem_raw_ecc = ~dmem_fix_ecc;
   endtask
   initial begin
      dmem_fix_data = 32'hA5A5_0F0F;
      dmem_fix_ecc = 7'h2A;
      quiet();
   end
   // one event for one cycle; f packs tag errors, oldest, {retire, nonspec, store} or sys kind
   task automatic post(input int k, input cmec_ecc_type e, input logic [3:0] f,
                       input logic [31:0] d);
      @(negedge clk);
      case (k)
         0: begin ic_tag_err = f; ic_data_err = d[3:0]; end
         1: begin ifetch_valid = 1'b1; ifetch_ecc = e; ifetch_oldest = f[0]; end
         2: begin imem_dma_valid = 1'b1; imem_dma_ecc = e; end
         3: begin dmem_valid = 1'b1; dmem_ecc = e; {dmem_retire, dmem_nonspec, dmem_is_store} = f[2:0];
            dmem_fix_data = d; dmem_fix_ecc = d[6:0]; end
         4: begin dmem_dma_valid = 1'b1; dmem_dma_ecc = e; end
         default: begin sys_rsp_valid = 1'b1; sys_rsp_err = 1'b1; sys_rsp_kind = f[1:0]; end
      endcase
      @(negedge clk);
      quiet();
   endtask
endmodule // cmec_pipe_model

/* File: tb_cmec_core_mem_errors.sv */
// self-checking bench for the core memory error counters
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
   $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb_cmec_core_mem_errors;
   import cmec_pkg::*;
   int               checked = 0, miscompares = 0;
   logic             clk = 1'b0, rst = 1'b1, csr_wr_en = 1'b0;
   logic [11:0]      csr_addr = 12'h000;
   logic [31:0]      csr_wr_data = 32'h0;
   wire logic [3:0]  ic_tag_err, ic_data_err;
   wire logic        ifetch_valid, ifetch_oldest, imem_dma_valid, dmem_valid, dmem_is_store;
   wire logic        dmem_nonspec, dmem_retire, dmem_dma_valid, sys_rsp_valid, sys_rsp_err;
   wire cmec_ecc_type ifetch_ecc, imem_dma_ecc, dmem_ecc, dmem_dma_ecc;
   wire logic [1:0]  sys_rsp_kind;
   wire logic [31:0] dmem_raw_data, dmem_fix_data, dmem_load_data, dmem_wb_data, csr_rd_data;
   wire logic [6:0]  dmem_raw_ecc, dmem_fix_ecc, dmem_wb_ecc;
   wire logic        csr_hit, imem_wb_en, refetch_flush, instr_access_fault, load_access_fault;
   wire logic        store_access_fault, store_bus_error_nmi, sys_data_discard, dma_err_rsp;
   wire logic        dmem_wb_en, ic_err_irq, imem_err_irq, corr_err_irq;
   cmec_pipe_model u_far (.*);
   cmec_core_mem_errors u_dut (.*);
   always #2 clk = ~clk;
   // register write: one-cycle strobe
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(negedge clk); csr_wr_en = 1'b1; csr_addr = a; csr_wr_data = d;
      @(negedge clk); csr_wr_en = 1'b0; csr_wr_data = ~d;
   endtask
   // register read: combinational, looked at once settled
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(negedge clk); csr_addr = a; #1;
      `CHK(csr_rd_data, e)
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // run takes about 70 cycles; cut off well beyond that
   initial begin
      #20000; miscompares++; test_done();
   end
   initial begin
      repeat (12) @(posedge clk);
      @(negedge clk); rst = 1'b0;
      rd(12'h7F0, 32'h0);
      rd(12'h7F1, 32'h0);
      rd(12'h7F2, 32'h0);
      wr(12'h7F0, 32'hF800_0005);
      rd(12'h7F0, 32'hD000_0005);
      wr(12'h7F0, 32'h0800_0000);
      u_far.post(0, CMEC_OK, 4'hF, 32'h0000_000F); // every way flags at once
      rd(12'h7F0, 32'h0800_0001);
      `CHK(ic_err_irq, 1'b0)
      u_far.post(0, CMEC_OK, 4'h0, 32'h0000_0002);
      rd(12'h7F0, 32'h0800_0002);
      rd(12'h7F0, 32'h0800_0002);
      `CHK(corr_err_irq, 1'b1)
      wr(12'h7F0, 32'h0800_0000);
      `CHK(corr_err_irq, 1'b0)
      wr(12'h7F1, 32'h07FF_FFFF);
      `CHK(imem_err_irq, 1'b1)
      u_far.post(2, CMEC_SBE, 4'h0, 32'h0); // dma read while core may sleep
      rd(12'h7F1, 32'h0);
      u_far.post(1, CMEC_SBE, 4'h0, 32'h0);
      `CHK({refetch_flush, imem_wb_en}, 2'b11)
      rd(12'h7F1, 32'h0000_0001);
      u_far.post(1, CMEC_DBE, 4'h0, 32'h0); // younger instruction
      `CHK(instr_access_fault, 1'b0)
      u_far.post(1, CMEC_DBE, 4'h1, 32'h0);
      `CHK(instr_access_fault, 1'b1)
      rd(12'h7F1, 32'h0000_0001);
      u_far.post(3, CMEC_SBE, 4'h6, 32'h1234_5678);
      `CHK({dmem_wb_en, dmem_wb_data, dmem_wb_ecc}, {1'b1, 32'h1234_5678, 7'h78})
      `CHK(dmem_load_data, 32'h1234_5678)
      u_far.post(3, CMEC_SBE, 4'h2, 32'h0);
      `CHK(dmem_wb_en, 1'b0)
      u_far.post(3, CMEC_DBE, 4'h2, 32'h0);
      `CHK(load_access_fault, 1'b1)
      u_far.post(3, CMEC_DBE, 4'h3, 32'h0);
      `CHK(store_access_fault, 1'b1)
      u_far.post(3, CMEC_DBE, 4'h1, 32'h0);
      `CHK(store_access_fault, 1'b0)
      u_far.post(4, CMEC_DBE, 4'h0, 32'h0);
      `CHK(dma_err_rsp, 1'b1)
      u_far.post(2, CMEC_DBE, 4'h0, 32'h0);
      `CHK({dma_err_rsp, imem_wb_en}, 2'b10)
      u_far.post(2, CMEC_SBE, 4'h0, 32'h0);
      `CHK({refetch_flush, imem_wb_en}, 2'b01)
      rd(12'h7F1, 32'h0000_0002);
      `CHK(csr_hit, 1'b1)
      rd(12'h7F3, 32'h0);
      `CHK(csr_hit, 1'b0)
      for (int k = 0; k < 3; k++) begin
         u_far.post(5, CMEC_OK, 4'(k), 32'h0);
         `CHK({instr_access_fault, load_access_fault, store_bus_error_nmi}, 3'b100 >> k)
         `CHK(sys_data_discard, 1'b1)
      end
      test_done();
   end
endmodule // tb_cmec_core_mem_errors
bind cmec_core_mem_errors cmec_core_mem_errors_asserts u_chk (.*);
